// ===== dwg_chan.sv
// One converter channel: held code, noise register, triangle counter, saturating sum.
// Assumes trigger is a single-cycle pulse already in the mclk domain.
`timescale 1ns/1ns
module dwg_chan (
	input wire logic mclk,
	input wire logic rst_n,
	input wire dwg_pkg::dwg_cfg_t cfg,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	input wire logic trig,
	output logic [11:0] code_out,
	output logic dma_req
);
	logic [11:0] held_output_code;
	logic [11:0] lfsr;
	logic [11:0] tri_cnt;
	logic tri_down;
	logic [11:0] next_held;
	logic [11:0] amp_mask;
	logic [11:0] lfsr_fb;
	logic [11:0] noise_val;
	logic [12:0] sum;
	logic [11:0] tri_top;
	logic go;

	// Mask of 2^N-1, N limited to 1..12
	function automatic logic [11:0] amp_of(input logic [3:0] n);
		logic [3:0] m;
		m = (n < dwg_pkg::AMP_N_MIN) ? dwg_pkg::AMP_N_MIN : (n > dwg_pkg::AMP_N_MAX) ? dwg_pkg::AMP_N_MAX : n;
		return 12'(({1'b0, 12'hFFF} >> (4'hC - m)) & 13'h0FFF);
	endfunction : amp_of

	// Alignment of the written code
	assign next_held = (cfg.fmt == dwg_pkg::DWG_FMT_L12) ? wr_data[15:4] :
		(cfg.fmt == dwg_pkg::DWG_FMT_R8) ? {wr_data[7:0], 4'h0} : wr_data[11:0];
	assign go = trig & cfg.enable;
	assign amp_mask = amp_of(cfg.amp_n);
	assign tri_top = amp_mask;
	// Feedback taps; zero state injects a one so the sequence cannot stall
	assign lfsr_fb = (lfsr == 12'h000) ? 12'h001 : {lfsr[10:0], lfsr[11] ^ lfsr[5] ^ lfsr[3] ^ lfsr[0]};
	assign noise_val = lfsr & amp_mask;
	// Sum chosen wave, clip at full scale instead of wrapping
	assign sum = {1'b0, held_output_code} + {1'b0, (cfg.wave == dwg_pkg::DWG_WAVE_NOISE) ? noise_val :
		(cfg.wave == dwg_pkg::DWG_WAVE_TRI) ? tri_cnt : 12'h000};

	// Held code register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			held_output_code <= 12'h000;
		end else if (wr_en) begin
			held_output_code <= next_held;
		end
	end

	// Noise register advances once per accepted trigger, only while the noise wave is selected
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lfsr <= dwg_pkg::LFSR_SEED;
		end else if (go && cfg.wave == dwg_pkg::DWG_WAVE_NOISE) begin
			lfsr <= lfsr_fb;
		end
	end

	// Up-down triangle between zero and 2^N-1
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tri_cnt <= 12'h000;
			tri_down <= 1'b0;
		end else if (go && cfg.wave == dwg_pkg::DWG_WAVE_TRI) begin
			if (!tri_down && tri_cnt >= tri_top) begin
				tri_down <= 1'b1;
				tri_cnt <= tri_cnt - 12'h001;
			end else if (tri_down && tri_cnt == 12'h000) begin
				tri_down <= 1'b0;
				tri_cnt <= 12'h001;
			end else begin
				tri_cnt <= tri_down ? tri_cnt - 12'h001 : tri_cnt + 12'h001;
			end
		end
	end

	// Output updates on trigger; request pulse follows the trigger
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			code_out <= 12'h000;
			dma_req <= 1'b0;
		end else begin
			dma_req <= go;
			if (go) begin
				code_out <= sum[12] ? dwg_pkg::CODE_MAX : sum[11:0];
			end
		end
	end

	seed_reset_a: assert property (@(posedge mclk) !rst_n |=> lfsr == dwg_pkg::LFSR_SEED) else $error("seed wrong");
	noise_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) !go |=> $stable(lfsr))
		else $error("lfsr moved");
	no_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
		lfsr == 12'h000 && go && cfg.wave == dwg_pkg::DWG_WAVE_NOISE |=> lfsr == 12'h001) else $error("lockup");
	sat_clip_a: assert property (@(posedge mclk) disable iff (!rst_n) go && sum[12] |=> code_out == 12'hFFF)
		else $error("wrapped");
	// Counter may sit above the top only after the amplitude was lowered under it
	tri_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tri_cnt > tri_top |-> $past(tri_cnt) > tri_top || $changed(tri_top)) else $error("tri above top");
	dma_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
		go |=> dma_req ##1 (dma_req == $past(go))) else $error("dma mismatch");
	noise_cov: cover property (@(posedge mclk) go && cfg.wave == dwg_pkg::DWG_WAVE_NOISE);
	tri_cov: cover property (@(posedge mclk) go && tri_down && tri_cnt == 12'h000);
	sat_cov: cover property (@(posedge mclk) go && sum[12]);
endmodule : dwg_chan

// ===== dwg_pkg.sv
// Package for the two-channel converter wave generation control.
// Assumes one system clock; no bus, all configuration arrives on plain ports.
package dwg_pkg;
	localparam int CODE_W = 12;
	localparam logic [11:0] LFSR_SEED = 12'hAAA;
	localparam logic [11:0] CODE_MAX = 12'hFFF;
	localparam logic [3:0] AMP_N_MIN = 4'h1;
	localparam logic [3:0] AMP_N_MAX = 4'hC;

	// Wave selection per channel
	typedef enum logic [1:0] {
		DWG_WAVE_NONE = 2'h0,
		DWG_WAVE_NOISE = 2'h1,
		DWG_WAVE_TRI = 2'h2
	} dwg_wave_t;

	// Input data format
	typedef enum logic [1:0] {
		DWG_FMT_R12 = 2'h0,
		DWG_FMT_L12 = 2'h1,
		DWG_FMT_R8 = 2'h2
	} dwg_fmt_t;

	// Per-channel configuration
	typedef struct packed {
		logic enable;
		dwg_fmt_t fmt;
		dwg_wave_t wave;
		logic [3:0] amp_n;
	} dwg_cfg_t;
endpackage : dwg_pkg

// ===== dwg_top.sv
// Two-channel wave generation control for a converter pair.
// Assumes trigger pins are asynchronous; software start and config come from mclk logic.
// Function
// - Two independent channels each take an 8-bit or 12-bit code.
// - In 12-bit mode the code may be left or right aligned.
// - The noise register is 12 bits and starts at 0xAAA.
// - A mask picks which noise bits are used.
// - An all-zero noise register gets a one injected.
// - Each trigger updates noise and adds it with saturation.
// - Each trigger updates the triangle and adds it limited by the amplitude.
// - The triangle counts up to the top then back down to the base.
// - The top is 2^N-1 with N from 1 to 12.
// - Each channel raises a DMA request on its trigger.
// - Eleven dual modes from independent, software-simultaneous and simultaneous triggers with waves.
// - In simultaneous mode both outputs update together on the shared trigger.
`timescale 1ns/1ns
module dwg_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire dwg_pkg::dwg_cfg_t cfg1,
	input wire dwg_pkg::dwg_cfg_t cfg2,
	input wire logic dual_sim,
	input wire logic wr1,
	input wire logic wr2,
	input wire logic [15:0] wr_data1,
	input wire logic [15:0] wr_data2,
	input wire logic ext_trig1,
	input wire logic ext_trig2,
	input wire logic sw_start,
	output logic [11:0] converter_output_pin1,
	output logic [11:0] converter_output_pin2,
	output logic dma_req1,
	output logic dma_req2
);
	logic [2:0] s1;
	logic [2:0] s2;
	logic edge1;
	logic edge2;
	logic t1;
	logic t2;

	// Two-stage sync then edge detect on stage three
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s1 <= 3'h0;
			s2 <= 3'h0;
		end else begin
			s1 <= {s1[1:0], ext_trig1};
			s2 <= {s2[1:0], ext_trig2};
		end
	end

	assign edge1 = s1[1] & ~s1[2];
	assign edge2 = s2[1] & ~s2[2];
	// Simultaneous mode shares channel one's trigger or a software start
	assign t1 = edge1 | sw_start;
	assign t2 = dual_sim ? t1 : (edge2 | sw_start);

	dwg_chan u_ch1 (.mclk(mclk), .rst_n(rst_n), .cfg(cfg1), .wr_en(wr1), .wr_data(wr_data1), .trig(t1),
		.code_out(converter_output_pin1), .dma_req(dma_req1));
	dwg_chan u_ch2 (.mclk(mclk), .rst_n(rst_n), .cfg(cfg2), .wr_en(wr2), .wr_data(wr_data2), .trig(t2),
		.code_out(converter_output_pin2), .dma_req(dma_req2));

	// Requests land on one edge in simultaneous mode; otherwise a pin edge reaches only its own channel
	sim_both_a: assert property (@(posedge mclk) disable iff (!rst_n)
		dual_sim && cfg1.enable && cfg2.enable && t1 |=> dma_req1 && dma_req2) else $error("not together");
	pin_req_a: assert property (@(posedge mclk) disable iff (!rst_n) edge1 && cfg1.enable |=> dma_req1)
		else $error("pin trigger lost");
	indep_trig_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!dual_sim && edge2 && !edge1 && !sw_start && cfg2.enable |=> dma_req2 && !dma_req1) else $error("crosstalk");
	sim_cov: cover property (@(posedge mclk) dual_sim && t1);
	indep_cov: cover property (@(posedge mclk) !dual_sim && edge2);
endmodule : dwg_top

// ===== dwg_trig_src.sv
// Trigger source model: raises an external trigger pin on request.
// Assumes go is a one-cycle request made in the mclk domain.
`timescale 1ns/1ns
module dwg_trig_src (
	input wire logic mclk,
	input wire logic go,
	output logic pin
);
	logic [2:0] hold = 3'h0;
	// Held high for four cycles so the two-flop sampler cannot miss it
	always_ff @(posedge mclk) begin
		hold <= go ? 3'h4 : hold - {2'h0, hold != 3'h0};
	end
	assign pin = hold != 3'h0;
endmodule : dwg_trig_src

// ===== dwg_top_tb_top.sv
// Bench for the two-channel wave control: table of plain codes, then hand tests.
// Assumes dwg_top and dwg_trig_src are compiled before it.
`timescale 1ns/1ns
module dwg_top_tb_top;
	typedef struct packed {dwg_pkg::dwg_fmt_t fmt; logic [15:0] d; logic [11:0] e;} dwg_row_t;
	dwg_row_t rows [4] = '{'{dwg_pkg::DWG_FMT_R12, 16'h0ABC, 12'hABC}, '{dwg_pkg::DWG_FMT_L12, 16'hABC0, 12'hABC},
		'{dwg_pkg::DWG_FMT_R8, 16'h00AB, 12'hAB0}, '{dwg_pkg::DWG_FMT_R12, 16'h0FFF, 12'hFFF}};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	dwg_pkg::dwg_cfg_t cfg = '0;
	logic dual_sim = 1'b0;
	logic wr = 1'b0;
	logic [15:0] wr_data = 16'h0000;
	logic sw_start = 1'b0;
	logic go = 1'b0;
	logic go2 = 1'b0;
	logic pin1;
	logic pin2;
	logic [11:0] out1, out2, prev;
	logic dma1, dma2;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	dwg_trig_src src_u (.mclk(mclk), .go(go), .pin(pin1));
	dwg_trig_src src2_u (.mclk(mclk), .go(go2), .pin(pin2));
	dwg_top dut_u (.mclk(mclk), .rst_n(rst_n), .cfg1(cfg), .cfg2(cfg), .dual_sim(dual_sim), .wr1(wr), .wr2(wr),
		.wr_data1(wr_data), .wr_data2(wr_data), .ext_trig1(pin1), .ext_trig2(pin2), .sw_start(sw_start),
		.converter_output_pin1(out1), .converter_output_pin2(out2), .dma_req1(dma1), .dma_req2(dma2));
	initial begin
		forever #25 mclk = ~mclk;
	end
	// Cuts a hang short well after the sequence should have ended
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_sim();
		end
	end
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	task load(input logic [15:0] d);
		@(negedge mclk) wr = 1'b1;
		wr_data = d;
		@(negedge mclk) wr = 1'b0;
	endtask : load
	// Returns half a cycle after the start is taken, while the one-cycle request still stands
	task trig;
		@(negedge mclk) sw_start = 1'b1;
		@(negedge mclk) sw_start = 1'b0;
	endtask : trig
	// Fires one pin, waits out the sync delay, then checks which requests stand
	task pin_trig(input logic use2, input logic e1, input logic e2);
		@(negedge mclk);
		go = !use2;
		go2 = use2;
		@(negedge mclk);
		go = 1'b0;
		go2 = 1'b0;
		for (int k = 0; k < 8 && (dma1 | dma2) !== 1'b1; k++) @(negedge mclk);
		chk({11'h0, dma1}, {11'h0, e1});
		chk({11'h0, dma2}, {11'h0, e2});
		$display("pin trigger test done");
	endtask : pin_trig
	initial begin
		repeat (4) @(negedge mclk);
		chk(out1, 12'h000);
		chk({11'h0, dma1}, 12'h0);
		$display("power-up reset test done");
		rst_n = 1'b1;
		cfg = '{1'b1, dwg_pkg::DWG_FMT_R12, dwg_pkg::DWG_WAVE_NONE, 4'h1};
		for (int i = 0; i < 4; i++) begin
			cfg.fmt = rows[i].fmt;
			load(rows[i].d);
			trig();
			chk(out1, rows[i].e);
			chk(out2, rows[i].e);
			chk({11'h0, dma1}, 12'h1);
			$display("row %0d done", i);
		end
		// Triangle of top 3 on a base of 0x100 moves one step per trigger
		cfg = '{1'b1, dwg_pkg::DWG_FMT_R12, dwg_pkg::DWG_WAVE_TRI, 4'h2};
		load(16'h0100);
		for (int i = 0; i < 9; i++) begin
			prev = out1;
			trig();
			chk({11'h0, out1 >= 12'h100 && out1 <= 12'h103}, 12'h1);
			if (i > 0) chk({11'h0, out1 - prev == 12'h1 || prev - out1 == 12'h1}, 12'h1);
			chk(out1, 12'h100 + 12'(i <= 3 ? i : (i <= 6 ? 6 - i : i - 6)));
		end
		$display("triangle test done");
		load(16'h0FFF);
		cfg.amp_n = 4'hC;
		trig();
		chk(out1, 12'hFFF);
		cfg.wave = dwg_pkg::DWG_WAVE_NOISE;
		trig();
		chk(out1, 12'hFFF);
		$display("saturation test done");
		cfg.enable = 1'b0;
		prev = out1;
		trig();
		chk({11'h0, dma1}, 12'h0);
		chk(out1, prev);
		$display("disabled test done");
		// Seed stepped once by the noise saturation trigger (taps 11,5,3,0): 0xAAA to 0x555, then 0xAAB
		cfg = '{1'b1, dwg_pkg::DWG_FMT_R12, dwg_pkg::DWG_WAVE_NOISE, 4'hC};
		load(16'h0000);
		trig();
		chk(out1, 12'h555);
		chk(out2, 12'h555);
		cfg.amp_n = 4'h4;
		trig();
		chk(out1, 12'h00B);
		$display("noise test done");
		// Reset in mid-run must clear the outputs and reseed the noise register
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		chk(out1, 12'h000);
		chk({11'h0, dma1}, 12'h0);
		rst_n = 1'b1;
		cfg.amp_n = 4'hC;
		load(16'h0000);
		trig();
		chk(out1, dwg_pkg::LFSR_SEED);
		$display("mid-run reset test done");
		cfg = '{1'b1, dwg_pkg::DWG_FMT_R12, dwg_pkg::DWG_WAVE_NONE, 4'h1};
		pin_trig(1'b0, 1'b1, 1'b0);
		pin_trig(1'b1, 1'b0, 1'b1);
		dual_sim = 1'b1;
		pin_trig(1'b0, 1'b1, 1'b1);
		pin_trig(1'b1, 1'b0, 1'b0);
		end_sim();
	end
endmodule : dwg_top_tb_top
